// *** design/uie_pkg.sv ***
// package of offsets, field layouts, reset values and types for the interrupt enable block
package uie_pkg;

  // register byte offsets on the avalon slave
  localparam logic [7:0]  OFS_INT_ENABLE = 8'h04;  // interrupt_enable
  localparam logic [7:0]  OFS_FIFO_LEVEL = 8'h08;  // rx and rts trigger level codes
  localparam logic [7:0]  OFS_INT_STATUS = 8'h1c;  // sticky event flags, write one to clear

  // interrupt_enable field positions
  localparam int BIT_RX_DMA    = 15;
  localparam int BIT_TX_DMA    = 14;
  localparam int BIT_AUTO_CTS  = 13;
  localparam int BIT_AUTO_RTS  = 12;
  localparam int BIT_TOUT_CNT  = 11;
  localparam int BIT_LIN_BRK   = 8;
  localparam int BIT_WAKE      = 6;
  localparam int BIT_BUF_ERR   = 5;
  localparam int BIT_RX_TOUT   = 4;
  localparam int BIT_MODEM     = 3;
  localparam int BIT_LINE_STS  = 2;
  localparam int BIT_TX_EMPTY  = 1;
  localparam int BIT_RX_AVAIL  = 0;

  // fifo level register field positions
  localparam int LVL_W         = 4;
  localparam int RX_LVL_LSB    = 4;
  localparam int RTS_LVL_LSB   = 16;

  // reset values
  localparam logic [31:0] IER_RST = 32'h0000_0000;
  localparam logic [31:0] FLV_RST = 32'h0000_0000;
  localparam logic [31:0] STS_RST = 32'h0000_0000;

  // implemented bits; everything else reads as zero
  localparam logic [31:0] IER_MASK_FULL = 32'h0000_f97f;
  localparam logic [31:0] IER_MASK_LITE = 32'h0000_0937;
  localparam logic [31:0] STS_MASK_FULL = 32'h0000_013f;
  localparam logic [31:0] STS_MASK_LITE = 32'h0000_0137;
  localparam logic [31:0] FLV_MASK_FULL = 32'h000f_00f0;
  localparam logic [31:0] FLV_MASK_LITE = 32'h0000_00f0;

  // channel instance that lacks dma, flow control, wake-up and modem interrupt
  localparam int CH_LITE = 2;

  // trigger level codes and their byte counts
  localparam logic [3:0] LVL_CODE_1  = 4'h0;
  localparam logic [3:0] LVL_CODE_4  = 4'h1;
  localparam logic [3:0] LVL_CODE_8  = 4'h2;
  localparam logic [3:0] LVL_CODE_14 = 4'h3;
  localparam logic [3:0] LVL_CODE_30 = 4'h4;
  localparam logic [3:0] LVL_CODE_46 = 4'h5;
  localparam logic [5:0] LVL_B1      = 6'h01;
  localparam logic [5:0] LVL_B4      = 6'h04;
  localparam logic [5:0] LVL_B8      = 6'h08;
  localparam logic [5:0] LVL_B14     = 6'h0e;
  localparam logic [5:0] LVL_B30     = 6'h1e;
  localparam logic [5:0] LVL_B46     = 6'h2e;
  localparam logic [5:0] LVL_B62     = 6'h3e;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } uie_bus_st_t;

  // event pulses from the rest of the channel
  typedef struct packed {
    logic lin_break;
    logic buf_err;
    logic rx_timeout;
    logic modem;
    logic line_status;
    logic tx_empty;
  } uie_evt_t;

  // feature enables handed to the rest of the channel
  typedef struct packed {
    logic rx_dma_en;
    logic tx_dma_en;
    logic timeout_cnt_en;
    logic lin_break_int_enable;
  } uie_ctl_t;

endpackage

// *** design/uie_lvl_dec.sv ***
// trigger level code to byte count decoder
`timescale 1ns/1ps
module uie_lvl_dec
  import uie_pkg::*;
(
  input  wire logic [3:0] code,        // level code from software
  input  wire logic       high_speed,  // channel runs the deep fifo
  output logic      [5:0] bytes        // byte count that trips the level
);

  // codes above 14 bytes only exist on the deep fifo; normal speed saturates at 14
  always_comb begin
    unique case (code)
      LVL_CODE_1:  bytes = LVL_B1;
      LVL_CODE_4:  bytes = LVL_B4;
      LVL_CODE_8:  bytes = LVL_B8;
      LVL_CODE_14: bytes = LVL_B14;
      LVL_CODE_30: bytes = high_speed ? LVL_B30 : LVL_B14;
      LVL_CODE_46: bytes = high_speed ? LVL_B46 : LVL_B14;
      default:     bytes = high_speed ? LVL_B62 : LVL_B14;
    endcase
  end

endmodule

// *** design/uie_ctrl.sv ***
// interrupt enable and feature enable register block of one uart channel
//
// Contract
// - enable register at 0x04, resets zero
// - bit 15 switches receive dma service
// - bit 14 switches transmit dma service
// - bit 13: transmit waits for cts
// - bit 12: drop rts at trigger level
// - bit 11 switches receive time-out counter
// - bit 8 gates lin break interrupt
// - bit 6: cts change wakes power-down
// - bit 5 gates buffer error interrupt
// - bit 4 gates receive time-out interrupt
// - bit 3 gates modem status interrupt
// - bit 2 gates line status interrupt
// - bit 1 gates transmit empty interrupt
// - bit 0 gates receive data interrupt
// - third channel lacks dma, flow, wake, modem
// - rts level codes map to byte counts
// - rx level match sets data flag
`timescale 1ns/1ps
module uie_ctrl
  import uie_pkg::*;
#(
  parameter int         CHANNEL    = 0,     // channel instance number
  parameter logic       HIGH_SPEED = 1'b0,  // deep fifo with 30/46/62 byte levels
  parameter int         CNT_W      = 7      // width of the rx fifo byte count
)
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire uie_pkg::uie_evt_t evt,
  input  wire logic [CNT_W-1:0]  rx_fifo_count,
  input  wire logic              cts_n,
  input  wire logic              power_down,
  output uie_pkg::uie_ctl_t      ctl,
  output logic                   tx_permit,
  output logic                   rts_n,
  output logic                   wake_req,
  output logic                   irq
);

  import uie_pkg::*;

  // the lite channel simply has no flops behind its missing bits
  localparam logic        IS_LITE  = (CHANNEL == CH_LITE);
  localparam logic [31:0] IER_MASK = IS_LITE ? IER_MASK_LITE : IER_MASK_FULL;
  localparam logic [31:0] STS_MASK = IS_LITE ? STS_MASK_LITE : STS_MASK_FULL;
  localparam logic [31:0] FLV_MASK = IS_LITE ? FLV_MASK_LITE : FLV_MASK_FULL;

  // register state
  logic [31:0]   ier_r;         // interrupt_enable
  logic [31:0]   flv_r;         // fifo trigger level codes
  logic [31:0]   sts_r;         // sticky event flags
  logic [31:0]   sts_nxt;       // next value of the flags
  uie_bus_st_t   bus_st_r;      // bus handshake state
  logic [31:0]   rdata_r;       // captured read data
  logic          wait_r;        // waitrequest flop
  logic          cts_prev_r;    // cts seen last cycle, for change detect
  logic          wake_r;        // wake request flop
  logic          irq_r;         // interrupt line flop
  logic          permit_r;      // transmit permission flop
  logic          rts_n_r;       // rts line flop
  uie_ctl_t      ctl_r;         // feature enables flop

  // decode helpers
  logic [31:0]   be_mask;       // byteenable widened to bits
  logic [31:0]   wr_bits;       // write data under the byte mask
  logic          wr_fire;       // write accepted this edge
  logic          hit_ier;       // address hits interrupt_enable
  logic          hit_flv;       // address hits the level register
  logic          hit_sts;       // address hits the status register
  logic [31:0]   rd_mux;        // read data before capture
  logic [31:0]   set_vec;       // event set pulses by flag position
  logic [5:0]    rx_lvl_bytes;  // decoded rx interrupt level
  logic [5:0]    rts_lvl_bytes; // decoded rts level
  logic [CNT_W-1:0] rx_lvl_cnt; // rx level at count width
  logic [CNT_W-1:0] rts_lvl_cnt;// rts level at count width
  logic          rx_lvl_hit;    // fifo count sits at rx level
  logic          rts_over;      // fifo count at or above rts level

  // avalon slave decode
  // one fixed wait state keeps the decode shallow; throughput is one
  // access every two cycles, ample for a configuration register, and the
  // read mux gets a whole cycle to settle before it is captured

  // byte lanes, so software can poke one byte without a read-modify-write
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_mask[8*i +: 8] = {8{avs_byteenable[i]}};
    end
  end

  assign wr_bits = avs_writedata & be_mask;
  assign hit_ier = (avs_address == OFS_INT_ENABLE);
  assign hit_flv = (avs_address == OFS_FIFO_LEVEL);
  assign hit_sts = (avs_address == OFS_INT_STATUS);

  // a write lands on the edge at which the master sees waitrequest low
  assign wr_fire = (bus_st_r == BUS_ACK) && avs_write;

  // read mux; unmapped addresses and reserved bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ier) begin
      rd_mux = ier_r & IER_MASK;
    end else if (hit_flv) begin
      rd_mux = flv_r & FLV_MASK;
    end else if (hit_sts) begin
      rd_mux = sts_r & STS_MASK;
    end
  end

  // handshake: one wait cycle, then waitrequest low for exactly one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_st_r <= BUS_IDLE;
      wait_r   <= 1'b1;
    end else begin
      unique case (bus_st_r)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_st_r <= BUS_ACK;
            wait_r   <= 1'b0;
          end
        end
        BUS_ACK: begin
          // the master drops its request after this edge
          bus_st_r <= BUS_IDLE;
          wait_r   <= 1'b1;
        end
      endcase
    end
  end

  // read data captured together with the falling waitrequest and held after
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_st_r == BUS_IDLE && avs_read) begin
      rdata_r <= rd_mux;
    end
  end

  // software registers
  // writes are masked by the implemented-bit pattern of this channel, so
  // reserved and absent bits can never be set and always read back zero;
  // byte lanes let one field change without touching its neighbours

  // interrupt_enable; unimplemented bits never leave zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ier_r <= IER_RST;
    end else if (wr_fire && hit_ier) begin
      ier_r <= ((ier_r & ~be_mask) | wr_bits) & IER_MASK;
    end
  end

  // level register: rx interrupt level and rts level codes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flv_r <= FLV_RST;
    end else if (wr_fire && hit_flv) begin
      flv_r <= ((flv_r & ~be_mask) | wr_bits) & FLV_MASK;
    end
  end

  // trigger levels
  // both level fields share one code table, so one decoder module serves both, one instance per field;
  // the decoders are combinational but feed flops only, so their depth
  // never reaches an output pin

  // rx interrupt level decode
  uie_lvl_dec u_rx_lvl (
    .code       (flv_r[RX_LVL_LSB +: LVL_W]),
    .high_speed (HIGH_SPEED),
    .bytes      (rx_lvl_bytes)
  );

  // rts level decode
  uie_lvl_dec u_rts_lvl (
    .code       (flv_r[RTS_LVL_LSB +: LVL_W]),
    .high_speed (HIGH_SPEED),
    .bytes      (rts_lvl_bytes)
  );

  // count width is a parameter, so the byte counts are resized explicitly
  assign rx_lvl_cnt  = CNT_W'(rx_lvl_bytes);
  assign rts_lvl_cnt = CNT_W'(rts_lvl_bytes);
  assign rx_lvl_hit  = (rx_fifo_count == rx_lvl_cnt);
  assign rts_over    = (rx_fifo_count >= rts_lvl_cnt);

  // sticky event flags
  // flags share the bit layout of interrupt_enable, so the interrupt term
  // is a plain bitwise and; software clears a flag by writing a one to it
  // and an event in the clearing cycle keeps its flag set

  // event pulses placed at the same positions as their enable bits
  always_comb begin
    set_vec               = 32'h0000_0000;
    set_vec[BIT_RX_AVAIL] = rx_lvl_hit;
    set_vec[BIT_TX_EMPTY] = evt.tx_empty;
    set_vec[BIT_LINE_STS] = evt.line_status;
    set_vec[BIT_MODEM]    = evt.modem;
    set_vec[BIT_RX_TOUT]  = evt.rx_timeout;
    set_vec[BIT_BUF_ERR]  = evt.buf_err;
    set_vec[BIT_LIN_BRK]  = evt.lin_break;
  end

  // per flag: a set in the clearing cycle wins, so no event is lost
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_flag
      always_comb begin
        if (!STS_MASK[g]) begin
          sts_nxt[g] = 1'b0;
        end else if (set_vec[g]) begin
          sts_nxt[g] = 1'b1;
        end else if (wr_fire && hit_sts && wr_bits[g]) begin
          sts_nxt[g] = 1'b0;
        end else begin
          sts_nxt[g] = sts_r[g];
        end
      end
    end
  endgenerate

  // flag storage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sts_r <= STS_RST;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  // interrupt line
  // a level, not a pulse: it stays high while any unmasked flag is set,
  // so a slow handler cannot miss an event; masking a flag hides it from
  // the line but leaves the flag itself set for polling

  // one level line; each enable bit gates the flag of the same position.
  // registered, so the line follows a flag change by one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(sts_r & ier_r & STS_MASK);
    end
  end

  // feature enables
  // enables reach the rest of the channel one cycle after the write lands;
  // the extra flop keeps the register fan-out off the bus timing path,
  // and absent features of the third channel simply see a constant zero

  // dma, time-out counter and lin enables handed to the channel
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctl_r <= '0;
    end else begin
      ctl_r.rx_dma_en            <= ier_r[BIT_RX_DMA];
      ctl_r.tx_dma_en            <= ier_r[BIT_TX_DMA];
      ctl_r.timeout_cnt_en       <= ier_r[BIT_TOUT_CNT];
      ctl_r.lin_break_int_enable <= ier_r[BIT_LIN_BRK];
    end
  end

  // flow control
  // cts and rts are active low at the pins; both paths are registered, so
  // each reacts one cycle after its input or enable changes; with the
  // enables clear the transmitter runs free and rts stays asserted

  // transmit permission: with auto cts the sender waits for cts low.
  // a byte already on the wire is not cut off; the sender checks per byte
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      permit_r <= 1'b1;
    end else begin
      permit_r <= !ier_r[BIT_AUTO_CTS] || !cts_n;
    end
  end

  // rts deasserted while the fifo sits at or above its level, so the
  // line stays off even if a byte arrives before the far end reacts
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rts_n_r <= 1'b0;
    end else begin
      rts_n_r <= ier_r[BIT_AUTO_RTS] && rts_over;
    end
  end

  // wake-up
  // a change of cts in either direction counts; the pin is taken as
  // synchronous, so a raw asynchronous pin needs a synchroniser in front;
  // the request lasts one cycle and is raised only in power-down

  // previous cts level for change detect
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // follow the pin in reset too, so release never shows a false edge
      cts_prev_r <= cts_n;
    end else begin
      cts_prev_r <= cts_n;
    end
  end

  // either edge of cts in power-down raises a one-cycle wake request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= ier_r[BIT_WAKE] && power_down && (cts_n != cts_prev_r);
    end
  end

  // outputs, all straight from flops
  // no output passes through logic after its flop, so the block adds
  // nothing to the input paths of whatever sits beside it; each output
  // has exactly one driving register above
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign ctl             = ctl_r;
  assign tx_permit       = permit_r;
  assign rts_n           = rts_n_r;
  assign wake_req        = wake_r;
  assign irq             = irq_r;

endmodule

// *** verif/uie_ctrl_properties.sv ***
// port-level checks of the interrupt enable block
`timescale 1ns/1ps
module uie_ctrl_props
  import uie_pkg::*;
#(
  parameter int   CHANNEL    = 0,
  parameter logic HIGH_SPEED = 1'b0,
  parameter int   CNT_W      = 7
)
(
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic [7:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire uie_pkg::uie_evt_t evt,
  input wire logic [CNT_W-1:0]  rx_fifo_count,
  input wire logic              cts_n,
  input wire logic              power_down,
  input wire uie_pkg::uie_ctl_t ctl,
  input wire logic              tx_permit,
  input wire logic              rts_n,
  input wire logic              wake_req,
  input wire logic              irq
);
  logic [31:0] ier_s;  // shadow of interrupt_enable
  logic [3:0]  rxc_s;  // shadow rx level code
  logic [3:0]  rtc_s;  // shadow rts level code
  logic [31:0] bm;     // byte lane mask of this write
  logic        wr_ok;  // write lands at this edge
  assign bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_ok = avs_write && !avs_waitrequest;
  // own decode, kept apart from the design's so a shared slip cannot hide
  function automatic logic [5:0] lvl(input logic [3:0] c);
    case (c)
      4'h0: return 6'h01;
      4'h1: return 6'h04;
      4'h2: return 6'h08;
      4'h3: return 6'h0e;
      4'h4: return HIGH_SPEED ? 6'h1e : 6'h0e;
      4'h5: return HIGH_SPEED ? 6'h2e : 6'h0e;
      default: return HIGH_SPEED ? 6'h3e : 6'h0e;
    endcase
  endfunction
  // shadows follow the bus, lanes honoured, unimplemented bits dropped
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ier_s <= '0;
      rxc_s <= '0;
      rtc_s <= '0;
    end else if (wr_ok && avs_address == OFS_INT_ENABLE) begin
      ier_s <= (ier_s & ~bm | avs_writedata & bm)
               & (CHANNEL == CH_LITE ? IER_MASK_LITE : IER_MASK_FULL);
    end else if (wr_ok && avs_address == OFS_FIFO_LEVEL) begin
      if (avs_byteenable[0]) rxc_s <= avs_writedata[7:4];
      if (avs_byteenable[2] && CHANNEL != CH_LITE) rtc_s <= avs_writedata[19:16];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  property p_evt(ev, en);
    ev ##1 en |=> irq;
  endproperty
  a_answer_once: assert property (s_taken |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not exactly one cycle");
  a_ctl_copy: assert property (ctl == {$past(ier_s[15]), $past(ier_s[14]),
    $past(ier_s[11]), $past(ier_s[8])}) else $error("feature enables wrong");
  a_cts_gate: assert property (tx_permit == (!$past(ier_s[13]) || !$past(cts_n)))
    else $error("transmit permit wrong");
  a_rts_level: assert property (rts_n == ($past(ier_s[12])
    && $past(rx_fifo_count) >= CNT_W'(lvl($past(rtc_s))))) else $error("rts wrong");
  a_cts_wake: assert property (wake_req == ($past(ier_s[6]) && $past(power_down)
    && $past(cts_n) != $past(cts_n, 2))) else $error("wake pulse wrong");
  a_irq_tx_empty: assert property (p_evt(evt.tx_empty, ier_s[1]))
    else $error("tx empty irq missing");
  a_irq_line_sts: assert property (p_evt(evt.line_status, ier_s[2]))
    else $error("line status irq missing");
  a_irq_buf_err: assert property (p_evt(evt.buf_err, ier_s[5]))
    else $error("buffer error irq missing");
  a_irq_lin_brk: assert property (p_evt(evt.lin_break, ier_s[8]))
    else $error("lin break irq missing");
  a_irq_rx_data: assert property (p_evt(rx_fifo_count == CNT_W'(lvl(rxc_s)), ier_s[0]))
    else $error("rx data irq missing");
  a_irq_masked: assert property ((ier_s & STS_MASK_FULL) == '0 |=> !irq)
    else $error("irq while all masked");
endmodule
bind uie_ctrl uie_ctrl_props #(.CHANNEL(CHANNEL), .HIGH_SPEED(HIGH_SPEED), .CNT_W(CNT_W))
  uie_ctrl_props_i (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .evt(evt), .rx_fifo_count(rx_fifo_count),
  .cts_n(cts_n), .power_down(power_down), .ctl(ctl), .tx_permit(tx_permit),
  .rts_n(rts_n), .wake_req(wake_req), .irq(irq));

// *** verif/uie_peer.sv ***
// far-side serial partner driving clear-to-send
`timescale 1ns/1ps
module uie_peer (
  input  wire logic mclk,
  input  wire logic busy,    // partner cannot take data
  input  wire logic wiggle,  // toggle clear-to-send each cycle
  output logic      cts_n
);
  initial cts_n = 1'b1;
  // grant only while able to take data; wiggle stirs the wake path
  always @(posedge mclk) begin
    if (wiggle) cts_n <= ~cts_n;
    else cts_n <= busy;
  end
endmodule

// *** verif/uie_ctrl_bench.sv ***
// self-checking bench for the interrupt enable block
`timescale 1ns/1ps
module uie_ctrl_bench;
  import uie_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd_lite, rd, rdl;
  logic        avs_waitrequest, cts_n, tx_permit, rts_n, wake_req, irq, rts_n_lite;
  uie_evt_t    evt = '0;
  uie_ctl_t    ctl, ctl_lite;
  logic [6:0]  rx_fifo_count = 7'h00;
  logic        power_down = 1'b0;
  logic        busy = 1'b0;
  logic        wiggle = 1'b0;
  int          err_count = 0;
  int          num_checks = 0;
  int          n;
  int          sbits[6] = '{1, 2, 3, 4, 5, 8};          // status bit of each event
  int          lv[8] = '{1, 4, 8, 14, 14, 14, 14, 14};  // normal-speed byte counts
  uie_ctrl uie_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .evt(evt), .rx_fifo_count(rx_fifo_count),
    .cts_n(cts_n), .power_down(power_down), .ctl(ctl), .tx_permit(tx_permit),
    .rts_n(rts_n), .wake_req(wake_req), .irq(irq));
  // third channel shares the bus; its timing matches the first
  uie_ctrl #(.CHANNEL(CH_LITE)) uie_ctrl_lite_i (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(rd_lite), .avs_waitrequest(), .evt(evt), .rx_fifo_count(rx_fifo_count),
    .cts_n(cts_n), .power_down(power_down), .ctl(ctl_lite), .tx_permit(),
    .rts_n(rts_n_lite), .wake_req(), .irq());
  uie_peer uie_peer_i (.mclk(mclk), .busy(busy), .wiggle(wiggle), .cts_n(cts_n));
  always #5 mclk = ~mclk;
  task automatic conclude();
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k == 50) err_count++;
    rd = avs_readdata;
    rdl = rd_lite;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rd, exp);
  endtask
  // one-cycle event pulse, then wait until irq has had time to move
  task automatic pulse(input int j);
    evt <= uie_evt_t'(6'h01 << j);
    @(posedge mclk);
    evt <= '0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wait2();
    repeat (2) @(posedge mclk);
  endtask
  initial begin
    #100us;
    err_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rchk(OFS_INT_ENABLE, IER_RST);
    check({ctl, tx_permit, rts_n, irq}, 7'b0000100);
    wr(OFS_INT_ENABLE, 32'hffff_ffff);
    rchk(OFS_INT_ENABLE, IER_MASK_FULL);
    check(rdl, IER_MASK_LITE);
    check({ctl, ctl_lite}, 8'hf3);
    bus(1'b1, OFS_INT_ENABLE, 32'h0, 4'h1);
    rchk(OFS_INT_ENABLE, 32'h0000_f900);
    wr(8'h40, 32'hffff_ffff);
    rchk(8'h40, 32'h0);
    wr(OFS_INT_ENABLE, 32'h0);
    // each event: masked, unmasked, cleared, then raised while enabled
    for (int j = 0; j < 6; j++) begin
      pulse(j);
      check(irq, 1'b0);
      rchk(OFS_INT_STATUS, 32'h1 << sbits[j]);
      wr(OFS_INT_ENABLE, 32'h1 << sbits[j]);
      wait2();
      check(irq, 1'b1);
      wr(OFS_INT_STATUS, 32'h1 << sbits[j]);
      wait2();
      check(irq, 1'b0);
      pulse(j);
      check(irq, 1'b1);
      wr(OFS_INT_ENABLE, 32'h0);
      wait2();
      check(irq, 1'b0);
      wr(OFS_INT_STATUS, 32'h1 << sbits[j]);
    end
    // rx level of four bytes: one short stays quiet, a match raises
    wr(OFS_FIFO_LEVEL, 32'h0000_0010);
    wr(OFS_INT_ENABLE, 32'h1);
    rx_fifo_count <= 7'd3;
    repeat (3) @(posedge mclk);
    check(irq, 1'b0);
    rx_fifo_count <= 7'd4;
    repeat (3) @(posedge mclk);
    check(irq, 1'b1);
    rx_fifo_count <= 7'd0;
    wr(OFS_INT_STATUS, 32'h1);
    // rts level codes 0 to 7, just under and at the level
    wr(OFS_INT_ENABLE, 32'hffff_ffff);
    wr(OFS_INT_ENABLE, 32'h1 << BIT_AUTO_RTS);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_FIFO_LEVEL, 32'(c) << RTS_LVL_LSB);
      rx_fifo_count <= 7'(lv[c] - 1);
      wait2();
      check(rts_n, 1'b0);
      rx_fifo_count <= 7'(lv[c]);
      wait2();
      check({rts_n, rts_n_lite}, 2'b10);
    end
    // clear-to-send gating only while auto-cts is on
    wr(OFS_INT_ENABLE, 32'h1 << BIT_AUTO_CTS);
    busy <= 1'b1;
    repeat (3) @(posedge mclk);
    check(tx_permit, 1'b0);
    wr(OFS_INT_ENABLE, 32'h0);
    wait2();
    check(tx_permit, 1'b1);
    busy <= 1'b0;
    // wake only with enable and power-down together
    for (int m = 0; m < 3; m++) begin
      wr(OFS_INT_ENABLE, (m == 1) ? 32'h0 : 32'h1 << BIT_WAKE);
      power_down <= (m != 2);
      wiggle <= 1'b1;
      n = 0;
      repeat (8) begin
        @(posedge mclk);
        if (wake_req === 1'b1) n++;
      end
      wiggle <= 1'b0;
      check(n > 4, m == 0);
    end
    conclude();
  end
endmodule
